// ==== elcr_bank.v ====
// event limit and calibration register bank with threshold hold logic
`timescale 1ns/1ps
// Notes on behaviour
// - a computation cycle is two to the power N line cycles, N being the accumulation exponent, held at 2^31 for N above 31.
// - rms current above the 32-bit over-current threshold records an event.
// - the over-current event waits until the breach has lasted the over-current hold count.
// - active power above the 32-bit over-power threshold records an event.
// - the over-power event waits until the breach has lasted the over-power hold count.
// - frequency above its threshold for its hold count records an over-frequency event.
// - frequency below its threshold for its hold count records an under-frequency event.
// - temperature above its threshold for its hold count records an over-temperature event.
// - temperature below its threshold for its hold count records an under-temperature event.
// - rms voltage is compared with separate sag and surge thresholds to record those events.
// - writable calibration targets for current, voltage, active and reactive power are held.
// - recorded events show in a read-only status register, only where enabled.
// - a 16-bit event enable register decides which events may be recorded.
`include "elcr_map.vh"
module elcr_bank (
  input wire clock,
  input wire rstn,
  input wire clk_en,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] addr,
  input wire [31:0] wr_data,
  output reg [31:0] rd_data,
  output reg rd_valid,
  input wire line_cycle,
  input wire [31:0] meas_current,
  input wire [15:0] meas_voltage,
  input wire [31:0] meas_power,
  input wire [15:0] meas_freq,
  input wire [15:0] meas_temp,
  input wire evt_clear,
  input wire [15:0] evt_clear_mask,
  output reg comp_done,
  output reg [15:0] evt_status,
  output wire [15:0] accum_exponent_out,
  output wire [31:0] cal_current_out,
  output wire [15:0] cal_voltage_out,
  output wire [31:0] cal_active_out,
  output wire [31:0] cal_reactive_out
);
  reg [31:0] cal_target_current;
  reg [15:0] cal_target_voltage;
  reg [31:0] cal_target_active_power;
  reg [31:0] cal_target_reactive_power;
  reg [15:0] accumulation_exponent;
  reg [31:0] overcurrent_threshold;
  reg [31:0] overpower_threshold;
  reg [15:0] high_freq_threshold;
  reg [15:0] low_freq_threshold;
  reg [15:0] high_temp_threshold;
  reg [15:0] low_temp_threshold;
  reg [15:0] sag_threshold;
  reg [15:0] surge_threshold;
  reg [15:0] overcurrent_hold_cycles;
  reg [15:0] overpower_hold_cycles;
  reg [15:0] high_freq_hold_cycles;
  reg [15:0] low_freq_hold_cycles;
  reg [15:0] high_temp_hold_cycles;
  reg [15:0] low_temp_hold_cycles;
  reg [15:0] event_enable;
  reg [31:0] line_count;
  reg [16:0] hold_count [0:`ELCR_EV_N-1];
  reg [`ELCR_EV_N-1:0] breach;
  reg [15:0] hold_limit [0:`ELCR_EV_N-1];
  reg [15:0] next_status;
  reg [16:0] next_count [0:`ELCR_EV_N-1];
  reg [31:0] next_rd;
  wire [31:0] period_lines;
  wire period_end;
  wire [4:0] sel;
  integer i;
  integer j;

  // select codes for mapped words; reserved and unmapped offsets share the none code
  localparam [4:0] SEL_NONE = 5'h00;
  localparam [4:0] SEL_CAL_CUR = 5'h01;
  localparam [4:0] SEL_CAL_VOLT = 5'h02;
  localparam [4:0] SEL_CAL_ACT = 5'h03;
  localparam [4:0] SEL_CAL_REACT = 5'h04;
  localparam [4:0] SEL_ACC_EXP = 5'h05;
  localparam [4:0] SEL_OC_LIM = 5'h06;
  localparam [4:0] SEL_OP_LIM = 5'h07;
  localparam [4:0] SEL_HF_LIM = 5'h08;
  localparam [4:0] SEL_LF_LIM = 5'h09;
  localparam [4:0] SEL_HT_LIM = 5'h0a;
  localparam [4:0] SEL_LT_LIM = 5'h0b;
  localparam [4:0] SEL_SAG_LIM = 5'h0c;
  localparam [4:0] SEL_SURGE_LIM = 5'h0d;
  localparam [4:0] SEL_OC_HOLD = 5'h0e;
  localparam [4:0] SEL_OP_HOLD = 5'h0f;
  localparam [4:0] SEL_HF_HOLD = 5'h10;
  localparam [4:0] SEL_LF_HOLD = 5'h11;
  localparam [4:0] SEL_HT_HOLD = 5'h12;
  localparam [4:0] SEL_LT_HOLD = 5'h13;
  localparam [4:0] SEL_STATUS = 5'h14;
  localparam [4:0] SEL_ENABLE = 5'h15;

  assign accum_exponent_out = accumulation_exponent;
  assign cal_current_out = cal_target_current;
  assign cal_voltage_out = cal_target_voltage;
  assign cal_active_out = cal_target_active_power;
  assign cal_reactive_out = cal_target_reactive_power;

  // exponents of 32 or more saturate at the widest period the counter holds
  function [31:0] pow2;
    input [15:0] n;
    begin
      if (n > 16'd31) begin
        pow2 = 32'h80000000;
      end else begin
        pow2 = 32'h00000001 << n[4:0];
      end
    end
  endfunction

  // saturating increment so a very long breach never wraps back below the hold count
  function [16:0] sat_inc;
    input [16:0] v;
    begin
      sat_inc = (v == 17'h1ffff) ? v : v + 17'h00001;
    end
  endfunction

  // one address decode serves the read mux and the write port, so they never disagree
  function [4:0] reg_sel;
    input [15:0] a;
    begin
      case (a)
        `ELCR_CAL_CURRENT: reg_sel = SEL_CAL_CUR;
        `ELCR_CAL_VOLTAGE: reg_sel = SEL_CAL_VOLT;
        `ELCR_CAL_ACTIVE: reg_sel = SEL_CAL_ACT;
        `ELCR_CAL_REACTIVE: reg_sel = SEL_CAL_REACT;
        `ELCR_ACC_EXP: reg_sel = SEL_ACC_EXP;
        `ELCR_OC_LIMIT: reg_sel = SEL_OC_LIM;
        `ELCR_OP_LIMIT: reg_sel = SEL_OP_LIM;
        `ELCR_HF_LIMIT: reg_sel = SEL_HF_LIM;
        `ELCR_LF_LIMIT: reg_sel = SEL_LF_LIM;
        `ELCR_HT_LIMIT: reg_sel = SEL_HT_LIM;
        `ELCR_LT_LIMIT: reg_sel = SEL_LT_LIM;
        `ELCR_SAG_LIMIT: reg_sel = SEL_SAG_LIM;
        `ELCR_SURGE_LIMIT: reg_sel = SEL_SURGE_LIM;
        `ELCR_OC_HOLD: reg_sel = SEL_OC_HOLD;
        `ELCR_OP_HOLD: reg_sel = SEL_OP_HOLD;
        `ELCR_HF_HOLD: reg_sel = SEL_HF_HOLD;
        `ELCR_LF_HOLD: reg_sel = SEL_LF_HOLD;
        `ELCR_HT_HOLD: reg_sel = SEL_HT_HOLD;
        `ELCR_LT_HOLD: reg_sel = SEL_LT_HOLD;
        `ELCR_EVT_STATUS: reg_sel = SEL_STATUS;
        `ELCR_EVT_ENABLE: reg_sel = SEL_ENABLE;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  assign sel = reg_sel(addr);
  assign period_lines = pow2(accumulation_exponent);
  assign period_end = line_cycle && (line_count + 32'h00000001 >= period_lines);

  always @* begin
    breach[`ELCR_EV_OC] = meas_current > overcurrent_threshold;
    breach[`ELCR_EV_OP] = meas_power > overpower_threshold;
    breach[`ELCR_EV_HF] = meas_freq > high_freq_threshold;
    breach[`ELCR_EV_LF] = meas_freq < low_freq_threshold;
    breach[`ELCR_EV_HT] = meas_temp > high_temp_threshold;
    breach[`ELCR_EV_LT] = meas_temp < low_temp_threshold;
    breach[`ELCR_EV_SAG] = meas_voltage < sag_threshold;
    breach[`ELCR_EV_SURGE] = meas_voltage > surge_threshold;
    hold_limit[`ELCR_EV_OC] = overcurrent_hold_cycles;
    hold_limit[`ELCR_EV_OP] = overpower_hold_cycles;
    hold_limit[`ELCR_EV_HF] = high_freq_hold_cycles;
    hold_limit[`ELCR_EV_LF] = low_freq_hold_cycles;
    hold_limit[`ELCR_EV_HT] = high_temp_hold_cycles;
    hold_limit[`ELCR_EV_LT] = low_temp_hold_cycles;
    // sag and surge have no hold register, so they record on the first breach
    hold_limit[`ELCR_EV_SAG] = 16'h0001;
    hold_limit[`ELCR_EV_SURGE] = 16'h0001;
  end

  // read mux; reserved words and unmapped offsets read as zero
  always @* begin
    case (sel)
      SEL_CAL_CUR: next_rd = cal_target_current;
      SEL_CAL_VOLT: next_rd = {16'h0000, cal_target_voltage};
      SEL_CAL_ACT: next_rd = cal_target_active_power;
      SEL_CAL_REACT: next_rd = cal_target_reactive_power;
      SEL_ACC_EXP: next_rd = {16'h0000, accumulation_exponent};
      SEL_OC_LIM: next_rd = overcurrent_threshold;
      SEL_OP_LIM: next_rd = overpower_threshold;
      SEL_HF_LIM: next_rd = {16'h0000, high_freq_threshold};
      SEL_LF_LIM: next_rd = {16'h0000, low_freq_threshold};
      SEL_HT_LIM: next_rd = {16'h0000, high_temp_threshold};
      SEL_LT_LIM: next_rd = {16'h0000, low_temp_threshold};
      SEL_SAG_LIM: next_rd = {16'h0000, sag_threshold};
      SEL_SURGE_LIM: next_rd = {16'h0000, surge_threshold};
      SEL_OC_HOLD: next_rd = {16'h0000, overcurrent_hold_cycles};
      SEL_OP_HOLD: next_rd = {16'h0000, overpower_hold_cycles};
      SEL_HF_HOLD: next_rd = {16'h0000, high_freq_hold_cycles};
      SEL_LF_HOLD: next_rd = {16'h0000, low_freq_hold_cycles};
      SEL_HT_HOLD: next_rd = {16'h0000, high_temp_hold_cycles};
      SEL_LT_HOLD: next_rd = {16'h0000, low_temp_hold_cycles};
      SEL_STATUS: next_rd = {16'h0000, evt_status};
      SEL_ENABLE: next_rd = {16'h0000, event_enable};
      default: next_rd = 32'h00000000;
    endcase
  end

  // register writes; the status word is read-only and ignores writes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cal_target_current <= `ELCR_RESET_32;
      cal_target_voltage <= `ELCR_RESET_16;
      cal_target_active_power <= `ELCR_RESET_32;
      cal_target_reactive_power <= `ELCR_RESET_32;
      accumulation_exponent <= `ELCR_RESET_16;
      overcurrent_threshold <= `ELCR_RESET_32;
      overpower_threshold <= `ELCR_RESET_32;
      high_freq_threshold <= `ELCR_RESET_16;
      low_freq_threshold <= `ELCR_RESET_16;
      high_temp_threshold <= `ELCR_RESET_16;
      low_temp_threshold <= `ELCR_RESET_16;
      sag_threshold <= `ELCR_RESET_16;
      surge_threshold <= `ELCR_RESET_16;
      overcurrent_hold_cycles <= `ELCR_RESET_16;
      overpower_hold_cycles <= `ELCR_RESET_16;
      high_freq_hold_cycles <= `ELCR_RESET_16;
      low_freq_hold_cycles <= `ELCR_RESET_16;
      high_temp_hold_cycles <= `ELCR_RESET_16;
      low_temp_hold_cycles <= `ELCR_RESET_16;
      event_enable <= `ELCR_RESET_16;
      rd_data <= 32'h00000000;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= next_rd;
      end
      if (wr_en) begin
        case (sel)
          SEL_CAL_CUR: cal_target_current <= wr_data;
          SEL_CAL_VOLT: cal_target_voltage <= wr_data[15:0];
          SEL_CAL_ACT: cal_target_active_power <= wr_data;
          SEL_CAL_REACT: cal_target_reactive_power <= wr_data;
          SEL_ACC_EXP: accumulation_exponent <= wr_data[15:0];
          SEL_OC_LIM: overcurrent_threshold <= wr_data;
          SEL_OP_LIM: overpower_threshold <= wr_data;
          SEL_HF_LIM: high_freq_threshold <= wr_data[15:0];
          SEL_LF_LIM: low_freq_threshold <= wr_data[15:0];
          SEL_HT_LIM: high_temp_threshold <= wr_data[15:0];
          SEL_LT_LIM: low_temp_threshold <= wr_data[15:0];
          SEL_SAG_LIM: sag_threshold <= wr_data[15:0];
          SEL_SURGE_LIM: surge_threshold <= wr_data[15:0];
          SEL_OC_HOLD: overcurrent_hold_cycles <= wr_data[15:0];
          SEL_OP_HOLD: overpower_hold_cycles <= wr_data[15:0];
          SEL_HF_HOLD: high_freq_hold_cycles <= wr_data[15:0];
          SEL_LF_HOLD: low_freq_hold_cycles <= wr_data[15:0];
          SEL_HT_HOLD: high_temp_hold_cycles <= wr_data[15:0];
          SEL_LT_HOLD: low_temp_hold_cycles <= wr_data[15:0];
          SEL_ENABLE: event_enable <= wr_data[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // computation cycle timing from line cycles
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line_count <= 32'h00000000;
      comp_done <= 1'b0;
    end else if (clk_en) begin
      comp_done <= period_end;
      if (period_end) begin
        line_count <= 32'h00000000;
      end else if (line_cycle) begin
        line_count <= line_count + 32'h00000001;
      end
    end
  end

  // next hold counts and flags; a set in the clear cycle wins over the clear
  always @* begin
    next_status = evt_status;
    if (evt_clear) begin
      next_status = next_status & ~evt_clear_mask;
    end
    for (j = 0; j < `ELCR_EV_N; j = j + 1) begin
      next_count[j] = hold_count[j];
      if (period_end) begin
        if (breach[j] && event_enable[j]) begin
          next_count[j] = sat_inc(hold_count[j]);
          if (next_count[j] >= {1'b0, hold_limit[j]}) begin
            next_status[j] = 1'b1;
          end
        end else begin
          next_count[j] = 17'h00000;
        end
      end
    end
  end

  // hold counters and sticky event flags
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `ELCR_EV_N; i = i + 1) begin
        hold_count[i] <= 17'h00000;
      end
      evt_status <= 16'h0000;
    end else if (clk_en) begin
      for (i = 0; i < `ELCR_EV_N; i = i + 1) begin
        hold_count[i] <= next_count[i];
      end
      evt_status <= next_status;
    end
  end
endmodule

// ==== elcr_bank_monitor.sv ====
// concurrent checks on the ports of the event limit and calibration bank
`timescale 1ns/1ps
module elcr_bank_monitor (
  input wire clock,
  input wire rstn,
  input wire clk_en,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] addr,
  input wire [31:0] wr_data,
  input wire [31:0] rd_data,
  input wire rd_valid,
  input wire line_cycle,
  input wire evt_clear,
  input wire [15:0] evt_clear_mask,
  input wire comp_done,
  input wire [15:0] evt_status,
  input wire [15:0] accum_exponent_out,
  input wire [31:0] cal_current_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_exp_write: assert property (
    clk_en && wr_en && addr == 16'h005a |=> accum_exponent_out == $past(wr_data[15:0]))
    else $error("exponent write not seen");
  a_done_cause: assert property (
    $rose(comp_done) |-> $past(line_cycle)) else $error("cycle end without line pulse");
  a_set_on_done: assert property (
    (evt_status & ~$past(evt_status)) != 16'h0 |-> comp_done)
    else $error("event set outside cycle end");
  a_clear_bits: assert property (
    clk_en && evt_clear |=> comp_done || (evt_status & $past(evt_clear_mask)) == 16'h0)
    else $error("clear ignored");
  a_rd_answer: assert property (
    clk_en && rd_en |=> rd_valid) else $error("read gave no valid");
  a_rd_status: assert property (
    clk_en && rd_en && addr == 16'h001c |=> rd_data == {16'h0, $past(evt_status)})
    else $error("status read wrong");
  a_rd_reserved: assert property (
    clk_en && rd_en && addr == 16'h005c |=> rd_data == 32'h0) else $error("reserved not zero");
  a_upper_zero: assert property (
    evt_status[15:8] == 8'h0) else $error("unused status bits set");
  a_frozen_state: assert property (
    !clk_en |=> $stable(evt_status) && $stable(cal_current_out)) else $error("state moved while frozen");
endmodule
bind elcr_bank elcr_bank_monitor i_mon (.clock(clock), .rstn(rstn), .clk_en(clk_en),
  .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
  .rd_valid(rd_valid), .line_cycle(line_cycle), .evt_clear(evt_clear),
  .evt_clear_mask(evt_clear_mask), .comp_done(comp_done), .evt_status(evt_status),
  .accum_exponent_out(accum_exponent_out), .cal_current_out(cal_current_out));

// ==== elcr_map.vh ====
// register offsets, field positions and reset values of the event, limit and calibration bank
`ifndef ELCR_MAP_VH
`define ELCR_MAP_VH
`define ELCR_ADDR_W 16
`define ELCR_CAL_CURRENT 16'h004c
`define ELCR_CAL_VOLTAGE 16'h0050
`define ELCR_CAL_ACTIVE 16'h0052
`define ELCR_CAL_REACTIVE 16'h0056
`define ELCR_ACC_EXP 16'h005a
`define ELCR_RSVD_A 16'h005c
`define ELCR_OC_LIMIT 16'h005e
`define ELCR_RSVD_B 16'h0062
`define ELCR_OP_LIMIT 16'h0064
`define ELCR_RSVD_C 16'h0068
`define ELCR_HF_LIMIT 16'h006a
`define ELCR_LF_LIMIT 16'h006c
`define ELCR_HT_LIMIT 16'h006e
`define ELCR_LT_LIMIT 16'h0070
`define ELCR_SAG_LIMIT 16'h0072
`define ELCR_SURGE_LIMIT 16'h0074
`define ELCR_OC_HOLD 16'h0076
`define ELCR_RSVD_D 16'h0078
`define ELCR_OP_HOLD 16'h007a
`define ELCR_RSVD_E 16'h007c
`define ELCR_HF_HOLD 16'h007e
`define ELCR_LF_HOLD 16'h0080
`define ELCR_HT_HOLD 16'h0082
`define ELCR_LT_HOLD 16'h0084
`define ELCR_RSVD_F 16'h0086
`define ELCR_EVT_STATUS 16'h001c
`define ELCR_EVT_ENABLE 16'h008a
`define ELCR_EV_OC 0
`define ELCR_EV_OP 1
`define ELCR_EV_HF 2
`define ELCR_EV_LF 3
`define ELCR_EV_HT 4
`define ELCR_EV_LT 5
`define ELCR_EV_SAG 6
`define ELCR_EV_SURGE 7
`define ELCR_EV_N 8
`define ELCR_RESET_16 16'h0000
`define ELCR_RESET_32 32'h00000000
`endif

// ==== tb.sv ====
// self-checking bench for the event limit and calibration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb;
  reg clock = 0, rstn = 0, clk_en = 1, wr_en = 0, rd_en = 0, line_cycle = 0, evt_clear = 0;
  reg [15:0] addr = 0, meas_voltage = 0, meas_freq = 0, meas_temp = 0, evt_clear_mask = 0;
  reg [31:0] wr_data = 0, meas_current = 0, meas_power = 0;
  wire [31:0] rd_data, cal_current_out, cal_active_out, cal_reactive_out;
  wire [15:0] evt_status, accum_exponent_out, cal_voltage_out;
  wire rd_valid, comp_done;
  integer num_errors = 0, n_compared = 0, i, n_done = 0;
  localparam [191:0] LST = {16'h004c, 16'h0050, 16'h0052, 16'h0056, 16'h005a, 16'h005c,
    16'h005e, 16'h0062, 16'h0064, 16'h008a, 16'h001c, 16'h0100};
  elcr_bank i_elcr_bank (.clock(clock), .rstn(rstn), .clk_en(clk_en), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .line_cycle(line_cycle), .meas_current(meas_current), .meas_voltage(meas_voltage),
    .meas_power(meas_power), .meas_freq(meas_freq), .meas_temp(meas_temp),
    .evt_clear(evt_clear), .evt_clear_mask(evt_clear_mask), .comp_done(comp_done),
    .evt_status(evt_status), .accum_exponent_out(accum_exponent_out),
    .cal_current_out(cal_current_out), .cal_voltage_out(cal_voltage_out),
    .cal_active_out(cal_active_out), .cal_reactive_out(cal_reactive_out));
  initial begin
    forever #4 clock = ~clock;
  end
  task print_verdict;
    begin
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task wr(input [15:0] a, input [31:0] d);
    begin
      @(negedge clock); wr_en = 1; addr = a; wr_data = d;
      @(negedge clock); wr_en = 0;
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      @(negedge clock); rd_en = 1; addr = a;
      @(negedge clock); rd_en = 0;
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, e)
    end
  endtask
  // reserved, unmapped and status places read zero; 16-bit places keep only the low half
  function [31:0] pat(input [15:0] a);
    case (a)
      16'h004c, 16'h0052, 16'h0056, 16'h005e, 16'h0064: pat = {~a, a};
      16'h005c, 16'h0062, 16'h0068, 16'h0078, 16'h007c, 16'h0086, 16'h001c, 16'h0100: pat = 0;
      default: pat = {16'h0, a};
    endcase
  endfunction
  task chkreg(input [15:0] a);
    begin
      rd(a, 0);
      wr(a, {~a, a});
      rd(a, pat(a));
    end
  endtask
  task pulses(input integer n);
    begin
      repeat (n) begin
        @(negedge clock); line_cycle = 1;
        @(negedge clock); line_cycle = 0;
        if (comp_done === 1'b1) n_done++;
      end
      @(negedge clock);
    end
  endtask
  task clr;
    begin
      @(negedge clock); evt_clear = 1; evt_clear_mask = 16'hffff;
      @(negedge clock); evt_clear = 0;
    end
  endtask
  task meas(input [31:0] c, input [31:0] p, input [15:0] f, input [15:0] t, input [15:0] v);
    begin
      meas_current = c; meas_power = p; meas_freq = f; meas_temp = t; meas_voltage = v;
    end
  endtask
  initial begin
    #100000;
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge clock);
    rstn = 1;
    for (i = 0; i < 16; i++) chkreg(16'h0068 + 2 * i);
    for (i = 0; i < 12; i++) chkreg(LST[16 * i +: 16]);
    `CHK(cal_current_out, 32'hffb3004c)
    `CHK(cal_voltage_out, 16'h0050)
    `CHK(cal_active_out, 32'hffad0052)
    `CHK(cal_reactive_out, 32'hffa90056)
    `CHK(accum_exponent_out, 16'h005a)
    $display("test register map done");
    // limits: oc 100, op 200, hf 50, lf 40, ht 60, lt 30, sag 10, surge 20
    wr(16'h005a, 2); wr(16'h005e, 100); wr(16'h0064, 200); wr(16'h006a, 50);
    wr(16'h006c, 40); wr(16'h006e, 60); wr(16'h0070, 30); wr(16'h0072, 10);
    wr(16'h0074, 20); wr(16'h0076, 2); wr(16'h007a, 1); wr(16'h007e, 2);
    wr(16'h0080, 2); wr(16'h0082, 2); wr(16'h0084, 2); wr(16'h008a, 16'h0001);
    meas(101, 0, 45, 45, 15);
    pulses(7);
    `CHK(evt_status, 16'h0000)
    `CHK(n_done, 1)
    pulses(1);
    `CHK(evt_status, 16'h0001)
    rd(16'h001c, 32'h1);
    clr;
    meas(100, 0, 45, 45, 15);
    pulses(4);
    meas(101, 0, 45, 45, 15);
    pulses(4);
    `CHK(evt_status, 16'h0000)
    pulses(4);
    `CHK(evt_status, 16'h0001)
    $display("test over-current hold done");
    clr;
    wr(16'h005a, 0); wr(16'h0076, 1); wr(16'h008a, 16'h00fd);
    meas(101, 201, 51, 61, 21);
    pulses(1);
    `CHK(evt_status, 16'h0081)
    pulses(1);
    `CHK(evt_status, 16'h0095)
    clr;
    `CHK(evt_status, 16'h0000)
    meas(0, 0, 39, 29, 9);
    pulses(1);
    `CHK(evt_status, 16'h0040)
    pulses(1);
    `CHK(evt_status, 16'h0068)
    wr(16'h008a, 16'h00ff);
    meas(0, 201, 39, 29, 9);
    pulses(1);
    `CHK(evt_status, 16'h006a)
    clk_en = 0;
    clr;
    pulses(1);
    clk_en = 1;
    `CHK(evt_status, 16'h006a)
    `CHK(n_done, 10)
    $display("test event thresholds done");
    print_verdict;
  end
endmodule
